/* rtl/mcpwm_top.sv */
// Implementation choices: strobed register access and the register addresses.
`timescale 1ns/10ps
`default_nettype none
module mcpwm_top #(
   parameter int CNT_W = 15
) (
   input  wire logic                clk_sys,
   input  wire logic                nrst,
   input  wire mcpwm_pkg::mcpwm_req_t req,
   output logic [15:0]              rdata,
   input  wire logic                cpu_idle,
   input  wire logic                write_protect_cfg,
   input  wire logic                fault_input_a_n,
   input  wire logic                fault_input_b_n,
   output logic                     fault_a_pulldown,
   output logic                     fault_b_pulldown,
   output logic [2:0]               pwm_high,
   output logic [2:0]               pwm_low,
   output logic [2:0]               pwm_high_oe,
   output logic [2:0]               pwm_low_oe,
   output logic                     tb_event
);
   if (CNT_W != mcpwm_pkg::CW) begin : g_chk
      $error("counter width must be fifteen");
   end

   // ------------------------------------------------------------
   // reset and pin synchronisers
   // ------------------------------------------------------------
   logic       rst_q1_reg;
   logic       rst_n;
   logic [1:0] fa_sync_reg;
   logic [1:0] fb_sync_reg;

   always_ff @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         rst_q1_reg <= 1'b0;
         rst_n      <= 1'b0;
      end else begin
         rst_q1_reg <= 1'b1;
         rst_n      <= rst_q1_reg;
      end
   end

   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         fa_sync_reg <= 2'b11;
         fb_sync_reg <= 2'b11;
      end else begin
         fa_sync_reg <= {fa_sync_reg[0], fault_input_a_n};
         fb_sync_reg <= {fb_sync_reg[0], fault_input_b_n};
      end
   end

   wire logic fa_low = ~fa_sync_reg[1];
   wire logic fb_low = ~fb_sync_reg[1];
   wire logic wr     = req.wr;
   wire logic acc    = req.wr | req.rd;

   // ------------------------------------------------------------
   // unlock sequencer
   // ------------------------------------------------------------
   mcpwm_pkg::mcpwm_ulk_t ulk_reg;
   mcpwm_pkg::mcpwm_ulk_t ulk_next;
   logic                  prot_ok;

   always_comb begin
      ulk_next = ulk_reg;
      if (acc) begin
         unique case (ulk_reg)
            mcpwm_pkg::ULK_IDLE,
            mcpwm_pkg::ULK_KEY1: begin
               if (wr && req.addr == mcpwm_pkg::A_UNLOCK_KEY &&
                   req.wdata == mcpwm_pkg::KEY_SECOND &&
                   ulk_reg == mcpwm_pkg::ULK_KEY1)
                  ulk_next = mcpwm_pkg::ULK_OPEN;
               else if (wr && req.addr == mcpwm_pkg::A_UNLOCK_KEY &&
                        req.wdata == mcpwm_pkg::KEY_FIRST)
                  ulk_next = mcpwm_pkg::ULK_KEY1;
               else
                  ulk_next = mcpwm_pkg::ULK_IDLE;
            end
            mcpwm_pkg::ULK_OPEN:
               ulk_next = mcpwm_pkg::ULK_IDLE;
         endcase
      end
   end

   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         ulk_reg <= mcpwm_pkg::ULK_IDLE;
      end else begin
         ulk_reg <= ulk_next;
      end
   end

   assign prot_ok = !write_protect_cfg || ulk_reg == mcpwm_pkg::ULK_OPEN;

   // ------------------------------------------------------------
   // registers and time base
   // ------------------------------------------------------------
   logic [15:0]      ctrl_reg, ctrl_next;
   logic [CNT_W-1:0] cnt_reg, cnt_next;
   logic [CNT_W-1:0] per_reg, per_next;
   logic             dir_reg, dir_next;
   logic [15:0]      pin_reg, pin_next;
   logic [15:0]      flta_reg, flta_next;
   logic [15:0]      fltb_reg, fltb_next;
   logic [CNT_W-1:0] duty_reg [3];
   logic [CNT_W-1:0] duty_next [3];
   logic [5:0]       pre_reg, pre_next;
   logic [3:0]       post_reg, post_next;
   logic             evt_reg, evt_next;
   logic             run, tick, bound, step_evt;
   mcpwm_pkg::mcpwm_mode_t mode;

   assign mode = mcpwm_pkg::mcpwm_mode_t'(ctrl_reg[mcpwm_pkg::MODE_LSB +: 2]);
   assign run  = ctrl_reg[mcpwm_pkg::ON_BIT] &&
                 !(cpu_idle && ctrl_reg[mcpwm_pkg::IDLE_BIT]);
   assign tick = run && pre_reg >=
                 mcpwm_pkg::presc_limit(ctrl_reg[mcpwm_pkg::PRE_LSB +: 2]);

   always_comb begin
      ctrl_next = ctrl_reg;
      cnt_next  = cnt_reg;
      per_next  = per_reg;
      dir_next  = dir_reg;
      pin_next  = pin_reg;
      flta_next = flta_reg;
      fltb_next = fltb_reg;
      duty_next = duty_reg;
      pre_next  = pre_reg;
      post_next = post_reg;
      evt_next  = 1'b0;
      bound     = 1'b0;
      step_evt  = 1'b0;
      if (run)
         pre_next = tick ? 6'h00 : pre_reg + 6'h01;
      if (tick) begin
         unique case (mode)
            mcpwm_pkg::MODE_FREE,
            mcpwm_pkg::MODE_SINGLE: begin
               if (cnt_reg >= per_reg) begin
                  cnt_next = '0;
                  bound    = 1'b1;
                  step_evt = 1'b1;
                  if (mode == mcpwm_pkg::MODE_SINGLE)
                     ctrl_next[mcpwm_pkg::ON_BIT] = 1'b0;
               end else begin
                  cnt_next = cnt_reg + 1'b1;
               end
            end
            mcpwm_pkg::MODE_UPDN,
            mcpwm_pkg::MODE_UPDN_DBL: begin
               if (!dir_reg && cnt_reg >= per_reg) begin
                  dir_next = 1'b1;
                  cnt_next = (cnt_reg == '0) ? cnt_reg : cnt_reg - 1'b1;
                  bound    = 1'b1;
                  step_evt = mode == mcpwm_pkg::MODE_UPDN_DBL;
               end else if (dir_reg && cnt_reg == '0) begin
                  dir_next = 1'b0;
                  cnt_next = cnt_reg + 1'b1;
                  bound    = 1'b1;
                  step_evt = 1'b1;
               end else if (dir_reg) begin
                  cnt_next = cnt_reg - 1'b1;
               end else begin
                  cnt_next = cnt_reg + 1'b1;
               end
            end
         endcase
      end
      if (step_evt) begin
         if (post_reg >= ctrl_reg[mcpwm_pkg::POST_LSB +: 4]) begin
            post_next = 4'h0;
            evt_next  = 1'b1;
         end else begin
            post_next = post_reg + 4'h1;
         end
      end
      if (wr) begin
         unique case (req.addr)
            mcpwm_pkg::A_TB_CTRL:
               ctrl_next = req.wdata & mcpwm_pkg::CTRL_MASK;
            mcpwm_pkg::A_TB_COUNT:
               cnt_next = req.wdata[CNT_W-1:0];
            mcpwm_pkg::A_TB_PERIOD:
               per_next = req.wdata[CNT_W-1:0];
            mcpwm_pkg::A_PIN_CTRL:
               if (prot_ok) pin_next = req.wdata & mcpwm_pkg::PIN_MASK;
            mcpwm_pkg::A_FLT_A_CTRL:
               if (prot_ok) flta_next = req.wdata & mcpwm_pkg::FLT_MASK;
            mcpwm_pkg::A_FLT_B_CTRL:
               if (prot_ok) fltb_next = req.wdata & mcpwm_pkg::FLT_MASK;
            mcpwm_pkg::A_DUTY1: duty_next[0] = req.wdata[CNT_W-1:0];
            mcpwm_pkg::A_DUTY2: duty_next[1] = req.wdata[CNT_W-1:0];
            mcpwm_pkg::A_DUTY3: duty_next[2] = req.wdata[CNT_W-1:0];
            default: ;
         endcase
      end
   end

   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         ctrl_reg <= '0;
         cnt_reg  <= '0;
         per_reg  <= '0;
         dir_reg  <= 1'b0;
         pin_reg  <= '0;
         flta_reg <= mcpwm_pkg::FLT_RST;
         fltb_reg <= mcpwm_pkg::FLT_RST;
         duty_reg <= '{default: '0};
         pre_reg  <= '0;
         post_reg <= '0;
         evt_reg  <= 1'b0;
      end else begin
         ctrl_reg <= ctrl_next;
         cnt_reg  <= cnt_next;
         per_reg  <= per_next;
         dir_reg  <= dir_next;
         pin_reg  <= pin_next;
         flta_reg <= flta_next;
         fltb_reg <= fltb_next;
         duty_reg <= duty_next;
         pre_reg  <= pre_next;
         post_reg <= post_next;
         evt_reg  <= evt_next;
      end
   end

   assign tb_event = evt_reg;

   // ------------------------------------------------------------
   // faults and outputs
   // ------------------------------------------------------------
   logic       flag_a_reg, flag_a_next;
   logic       flag_b_reg, flag_b_next;
   logic       blk_reg, blk_next;
   logic [2:0] hi_reg, hi_next;
   logic [2:0] lo_reg, lo_next;
   logic       act_a, act_b, clr_a, clr_b, st_wr;
   logic [2:0] raw;

   assign st_wr = wr && req.addr == mcpwm_pkg::A_FLT_STATUS;
   assign clr_a = st_wr && req.wdata[mcpwm_pkg::STAT_FLAG_A] && !fa_low;
   assign clr_b = st_wr && req.wdata[mcpwm_pkg::STAT_FLAG_B] && !fb_low;
   assign act_a = flta_reg[mcpwm_pkg::FLT_EN_BIT] &&
                  (flta_reg[mcpwm_pkg::FLT_LATCH_BIT] ? flag_a_reg : fa_low);
   assign act_b = fltb_reg[mcpwm_pkg::FLT_EN_BIT] &&
                  (fltb_reg[mcpwm_pkg::FLT_LATCH_BIT] ? flag_b_reg : fb_low);

   always_comb begin
      flag_a_next = (flta_reg[mcpwm_pkg::FLT_EN_BIT] && fa_low) ||
                    (flag_a_reg && !clr_a);
      flag_b_next = (fltb_reg[mcpwm_pkg::FLT_EN_BIT] && fb_low) ||
                    (flag_b_reg && !clr_b);
      if (act_a || act_b)
         blk_next = 1'b1;
      else if (bound)
         blk_next = 1'b0;
      else
         blk_next = blk_reg;
      for (int i = 0; i < 3; i++) begin
         raw[i]     = cnt_reg < duty_reg[i];
         hi_next[i] = raw[i] && pin_reg[mcpwm_pkg::PENH_LSB + i] && !blk_next;
         lo_next[i] = (pin_reg[mcpwm_pkg::PMOD_LSB + i] ? raw[i] : !raw[i]) &&
                      pin_reg[mcpwm_pkg::PENL_LSB + i] && !blk_next;
      end
   end

   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         flag_a_reg <= 1'b0;
         flag_b_reg <= 1'b0;
         blk_reg    <= 1'b1;
         hi_reg     <= 3'h0;
         lo_reg     <= 3'h0;
      end else begin
         flag_a_reg <= flag_a_next;
         flag_b_reg <= flag_b_next;
         blk_reg    <= blk_next;
         hi_reg     <= hi_next;
         lo_reg     <= lo_next;
      end
   end

   assign pwm_high         = hi_reg;
   assign pwm_low          = lo_reg;
   assign pwm_high_oe      = pin_reg[mcpwm_pkg::PENH_LSB +: 3];
   assign pwm_low_oe       = pin_reg[mcpwm_pkg::PENL_LSB +: 3];
   assign fault_a_pulldown = flta_reg[mcpwm_pkg::FLT_EN_BIT];
   assign fault_b_pulldown = fltb_reg[mcpwm_pkg::FLT_EN_BIT];

   // ------------------------------------------------------------
   // read port
   // ------------------------------------------------------------
   logic [15:0] rd_reg, rd_next;

   always_comb begin
      rd_next = 16'h0000;
      if (req.rd) begin
         unique case (req.addr)
            mcpwm_pkg::A_TB_CTRL:    rd_next = ctrl_reg;
            mcpwm_pkg::A_TB_COUNT:   rd_next = {dir_reg, cnt_reg};
            mcpwm_pkg::A_TB_PERIOD:  rd_next = {1'b0, per_reg};
            mcpwm_pkg::A_PIN_CTRL:   rd_next = pin_reg;
            mcpwm_pkg::A_FLT_A_CTRL: rd_next = flta_reg;
            mcpwm_pkg::A_FLT_B_CTRL: rd_next = fltb_reg;
            mcpwm_pkg::A_DUTY1:      rd_next = {1'b0, duty_reg[0]};
            mcpwm_pkg::A_DUTY2:      rd_next = {1'b0, duty_reg[1]};
            mcpwm_pkg::A_DUTY3:      rd_next = {1'b0, duty_reg[2]};
            mcpwm_pkg::A_FLT_STATUS: begin
               rd_next[mcpwm_pkg::STAT_FLAG_A]  = flag_a_reg;
               rd_next[mcpwm_pkg::STAT_FLAG_B]  = flag_b_reg;
               rd_next[mcpwm_pkg::STAT_BLOCKED] = blk_reg;
            end
            default: rd_next = 16'h0000;
         endcase
      end
   end

   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         rd_reg <= 16'h0000;
      end else begin
         rd_reg <= rd_next;
      end
   end

   assign rdata = rd_reg;

   // ------------------------------------------------------------
   // assertions
   // ------------------------------------------------------------
   wire logic comp0  = !pin_reg[mcpwm_pkg::PMOD_LSB] && pin_reg[0] &&
                       pin_reg[4] && !blk_next;
   wire logic lockwr = wr && write_protect_cfg && req.addr ==
                       mcpwm_pkg::A_PIN_CTRL && ulk_reg != mcpwm_pkg::ULK_OPEN;
   wire logic up_top = tick && !dir_reg && cnt_reg >= per_reg &&
                       (mode == mcpwm_pkg::MODE_UPDN ||
                        mode == mcpwm_pkg::MODE_UPDN_DBL);
   wire logic rd_per = req.rd && req.addr == mcpwm_pkg::A_TB_PERIOD;

   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!rst_n);

   AST_COMPLEMENT: assert property (
      comp0 |=> pwm_low[0] == !pwm_high[0])
      else $error("low output not complement of high");
   AST_FAULT_SAFE: assert property (
      (act_a || act_b) |=> pwm_high == 3'h0 && pwm_low == 3'h0)
      else $error("outputs not safe during fault");
   AST_PULLDOWN: assert property (
      fault_a_pulldown && fa_low |=> flag_a_reg)
      else $error("pulled-down low fault pin did not raise fault");
   AST_RESET_LATCHED: assert property (
      $rose(rst_q1_reg) |=> flta_reg == mcpwm_pkg::FLT_RST &&
                            fltb_reg == mcpwm_pkg::FLT_RST)
      else $error("faults not latched-enabled after reset");
   AST_RESTORE: assert property (
      $fell(blk_reg) |-> $past(bound) && !$past(act_a) && !$past(act_b))
      else $error("outputs restored off a boundary");
   AST_LOCKED: assert property (
      lockwr |=> $stable(pin_reg))
      else $error("protected register written while locked");
   AST_KEY_BREAK: assert property (
      ulk_reg == mcpwm_pkg::ULK_KEY1 && acc &&
      !(wr && req.addr == mcpwm_pkg::A_UNLOCK_KEY) |=>
      ulk_reg == mcpwm_pkg::ULK_IDLE)
      else $error("foreign access did not void unlock");
   AST_ONE_WRITE: assert property (
      ulk_reg == mcpwm_pkg::ULK_OPEN && acc |=> ulk_reg == mcpwm_pkg::ULK_IDLE)
      else $error("unlock survived an access");
   AST_PRESCALE4: assert property (
      tick && ctrl_reg[mcpwm_pkg::PRE_LSB +: 2] == 2'b01 && !wr |=>
      (!tick || ctrl_reg[mcpwm_pkg::PRE_LSB +: 2] != 2'b01) [*3])
      else $error("prescale 1:4 tick spacing wrong");
   AST_REVERSE: assert property (
      up_top && !wr |=> dir_reg)
      else $error("no reversal at period");
   AST_PERIOD_TOP: assert property (
      rd_per |=> rdata[15] == 1'b0)
      else $error("period top bit not zero");

   COV_UNLOCK: cover property (ulk_reg == mcpwm_pkg::ULK_OPEN && wr &&
                               req.addr == mcpwm_pkg::A_PIN_CTRL);
   COV_FAULT: cover property ($fell(blk_reg));
   COV_EVENT: cover property (tb_event);
   COV_DOWN:  cover property ($rose(dir_reg));
endmodule
`default_nettype wire

/* rtl/mcpwm_pkg.sv */
// Summary of operation
// - three generators, six pins, complementary low inverted
// - any asserted fault whose enable bit is set forces safe outputs
// - enabled owned fault pin enables pull-down
// - reset keeps fault pins, latched faults enabled
// - outputs restored at period or half-period
// - lock guards pin and fault control registers
// - key pair ABCD then 4321 unlocks
// - protected write must be next access
// - one unlock grants exactly one write
// - control bit 15 turns time base on
// - idle-halt bit stops time base in idle
// - postscale divides events by value plus one
// - prescale 1, 4, 16 or 64 cycles
// - mode field selects one of four modes
// - count bit 15 reads count direction
// - count bits 14-0 readable and writable
// - period 15 bits, top bit reads zero
package mcpwm_pkg;
   localparam int          CW            = 15;
   // ------------------------------------------------------------
   // register offsets
   // ------------------------------------------------------------
   localparam logic [3:0]  A_TB_CTRL     = 4'h0;
   localparam logic [3:0]  A_TB_COUNT    = 4'h1;
   localparam logic [3:0]  A_TB_PERIOD   = 4'h2;
   localparam logic [3:0]  A_PIN_CTRL    = 4'h3;
   localparam logic [3:0]  A_FLT_A_CTRL  = 4'h4;
   localparam logic [3:0]  A_FLT_B_CTRL  = 4'h5;
   localparam logic [3:0]  A_UNLOCK_KEY  = 4'h6;
   localparam logic [3:0]  A_DUTY1       = 4'h7;
   localparam logic [3:0]  A_DUTY2       = 4'h8;
   localparam logic [3:0]  A_DUTY3       = 4'h9;
   localparam logic [3:0]  A_FLT_STATUS  = 4'hA;
   // ------------------------------------------------------------
   // fields and values
   // ------------------------------------------------------------
   localparam int          ON_BIT        = 15;
   localparam int          IDLE_BIT      = 13;
   localparam int          POST_LSB      = 4;
   localparam int          PRE_LSB       = 2;
   localparam int          MODE_LSB      = 0;
   localparam logic [15:0] CTRL_MASK     = 16'hA0FF;
   localparam int          DIR_BIT       = 15;
   localparam logic [15:0] KEY_FIRST     = 16'hABCD;
   localparam logic [15:0] KEY_SECOND    = 16'h4321;
   localparam int          FLT_EN_BIT    = 0;
   localparam int          FLT_LATCH_BIT = 1;
   localparam logic [15:0] FLT_RST       = 16'h0003;
   localparam logic [15:0] FLT_MASK      = 16'h0003;
   localparam logic [15:0] PIN_MASK      = 16'h0777;
   localparam int          PMOD_LSB      = 8;
   localparam int          PENH_LSB      = 4;
   localparam int          PENL_LSB      = 0;
   localparam int          STAT_FLAG_A   = 0;
   localparam int          STAT_FLAG_B   = 1;
   localparam int          STAT_BLOCKED  = 4;

   typedef enum logic [1:0] {
      MODE_FREE, MODE_SINGLE, MODE_UPDN, MODE_UPDN_DBL
   } mcpwm_mode_t;

   typedef enum logic [1:0] {ULK_IDLE, ULK_KEY1, ULK_OPEN} mcpwm_ulk_t;

   typedef struct packed {
      logic        wr;
      logic        rd;
      logic [3:0]  addr;
      logic [15:0] wdata;
   } mcpwm_req_t;

   // prescale terminal count: 1, 4, 16, 64 cycles
   function automatic logic [5:0] presc_limit(input logic [1:0] sel);
      unique case (sel)
         2'b00: presc_limit = 6'h00;
         2'b01: presc_limit = 6'h03;
         2'b10: presc_limit = 6'h0F;
         2'b11: presc_limit = 6'h3F;
      endcase
   endfunction
endpackage

/* verif/mcpwm_fault_src.sv */
`timescale 1ns/10ps
`default_nettype none
// ------------------------------------------------------------
// fault circuitry and power stage on one fault pin
// ------------------------------------------------------------
module mcpwm_fault_src (
   input  wire logic       clk_sys,
   input  wire logic       connected,
   input  wire logic       fault_cmd,
   input  wire logic       pull_en,
   input  wire logic [2:0] pwm_high,
   input  wire logic [2:0] pwm_low,
   output logic            pin_n,
   output logic            shoot
);
   logic toggle_reg = 1'b0;

   always_ff @(posedge clk_sys) begin
      toggle_reg <= ~toggle_reg;
   end

   // broken wire: pull-down wins, else a floating pattern
   always_comb begin
      if (connected) begin
         pin_n = ~fault_cmd;
      end else if (pull_en) begin
         pin_n = 1'b0;
      end else begin
         pin_n = toggle_reg;
      end
   end

   // both switches of a complementary leg on
   assign shoot = |(pwm_high & pwm_low);
endmodule
`default_nettype wire

/* verif/motor_pwm_time_base_faults_test.sv */
`timescale 1ns/10ps
`default_nettype none
module motor_pwm_time_base_faults_test;
   logic                  clk_sys, nrst, cpu_idle, wp, ev, rd_pend;
   logic                  pd_a, pd_b, pin_a, pin_b, sh_a, sh_b;
   logic                  con_a, con_b, flt_a, flt_b;
   logic [2:0]            hi, lo, hi_oe, lo_oe;
   logic [15:0]           rdata, v;
   logic [31:0]           exp_w;
   logic [31:0]           exp_q[$];
   mcpwm_pkg::mcpwm_req_t req;
   int                    failures, check_count, cycles, n, k;
   logic [15:0]           tctl[6] = '{16'h8000, 16'h8014, 16'h8002,
                                      16'h800B, 16'h800F, 16'h80F0};
   logic [15:0]           tper[6] = '{16'h3, 16'h2, 16'h3,
                                      16'h2, 16'h1, 16'h1};
   int                    tgap[6] = '{4, 24, 6, 32, 64, 32};

   mcpwm_top #(.CNT_W(15)) dut (
      .clk_sys(clk_sys), .nrst(nrst), .req(req), .rdata(rdata),
      .cpu_idle(cpu_idle), .write_protect_cfg(wp),
      .fault_input_a_n(pin_a), .fault_input_b_n(pin_b),
      .fault_a_pulldown(pd_a), .fault_b_pulldown(pd_b),
      .pwm_high(hi), .pwm_low(lo), .pwm_high_oe(hi_oe),
      .pwm_low_oe(lo_oe), .tb_event(ev));
   mcpwm_fault_src src_a (.clk_sys(clk_sys), .connected(con_a),
      .fault_cmd(flt_a), .pull_en(pd_a), .pwm_high(hi), .pwm_low(lo),
      .pin_n(pin_a), .shoot(sh_a));
   mcpwm_fault_src src_b (.clk_sys(clk_sys), .connected(con_b),
      .fault_cmd(flt_b), .pull_en(pd_b), .pwm_high(hi), .pwm_low(lo),
      .pin_n(pin_b), .shoot(sh_b));

   // ------------------------------------------------------------
   // shared tasks
   // ------------------------------------------------------------
   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      check_count++;
      if (seen !== exp) begin
         failures++;
         $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   task automatic end_of_test();
      $display("checks %0d failures %0d", check_count, failures);
      if (failures == 0 && check_count > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask
   task automatic wr(input logic [3:0] a, input logic [15:0] d);
      @(posedge clk_sys);
      req <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
   endtask
   task automatic rd(input logic [3:0] a, input logic [15:0] e,
                     input logic [15:0] m);
      @(posedge clk_sys);
      req <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 16'h0000};
      exp_q.push_back({m, e & m});
   endtask
   task automatic idle(input int c);
      @(posedge clk_sys);
      req <= '0;
      repeat (c) @(posedge clk_sys);
   endtask
   task automatic gap(output int g);
      g = 1;
      @(posedge clk_sys);
      while (ev !== 1'b1 && g < 3000) begin
         @(posedge clk_sys);
         g++;
      end
   endtask
   task automatic count_ev(input int c, output int e);
      e = 0;
      repeat (c) begin
         @(posedge clk_sys);
         if (ev === 1'b1) e++;
      end
   endtask
   task automatic watch(input logic live, input int c);
      logic [2:0] seen;
      seen = 3'b000;
      repeat (c) begin
         @(posedge clk_sys);
         seen = seen | hi;
         if (live) check({13'h0, lo}, {13'h0, ~hi});
         else check({10'h0, hi, lo}, 16'h0000);
      end
      if (live) check({13'h0, seen}, 16'h0007);
   endtask
   task automatic tb_setup(input logic [15:0] per, input logic [15:0] c);
      wr(mcpwm_pkg::A_TB_CTRL, 16'h0000);
      wr(mcpwm_pkg::A_TB_COUNT, 16'h0000);
      wr(mcpwm_pkg::A_TB_PERIOD, per);
      wr(mcpwm_pkg::A_TB_CTRL, c);
      idle(0);
   endtask
   task automatic unlock();
      wr(mcpwm_pkg::A_UNLOCK_KEY, mcpwm_pkg::KEY_FIRST);
      wr(mcpwm_pkg::A_UNLOCK_KEY, mcpwm_pkg::KEY_SECOND);
   endtask

   // ------------------------------------------------------------
   // read-data and pin monitor
   // ------------------------------------------------------------
   always @(posedge clk_sys) begin
      if (rd_pend === 1'b1) begin
         exp_w = exp_q.pop_front();
         check(rdata & exp_w[31:16], exp_w[15:0]);
      end
      if ((sh_a | sh_b) === 1'b1) check({15'h0, sh_a | sh_b}, 16'h0000);
      rd_pend <= req.rd;
      cycles++;
      if (cycles == 60000) begin
         failures++;
         end_of_test();
      end
   end

   initial begin
      clk_sys = 1'b0;
      forever #5 clk_sys = ~clk_sys;
   end

   // ------------------------------------------------------------
   // main sequence
   // ------------------------------------------------------------
   initial begin
      nrst = 1'b0; cpu_idle = 1'b0; wp = 1'b1; req = '0;
      con_a = 1'b1; con_b = 1'b1; flt_a = 1'b0; flt_b = 1'b0;
      failures = 0; check_count = 0; cycles = 0;
      void'($urandom(32'h6ADA));
      repeat (5) @(posedge clk_sys);
      nrst <= 1'b1;
      repeat (3) @(posedge clk_sys);
      check({14'h0, pd_a, pd_b}, 16'h0003);
      check({10'h0, hi, lo}, 16'h0000);
      rd(mcpwm_pkg::A_FLT_A_CTRL, 16'h0003, 16'hFFFF);
      rd(mcpwm_pkg::A_FLT_B_CTRL, 16'h0003, 16'hFFFF);
      wr(mcpwm_pkg::A_PIN_CTRL, 16'h0077);
      rd(mcpwm_pkg::A_PIN_CTRL, 16'h0000, 16'hFFFF);
      wr(mcpwm_pkg::A_UNLOCK_KEY, mcpwm_pkg::KEY_FIRST);
      rd(mcpwm_pkg::A_PIN_CTRL, 16'h0000, 16'hFFFF);
      wr(mcpwm_pkg::A_UNLOCK_KEY, mcpwm_pkg::KEY_SECOND);
      wr(mcpwm_pkg::A_PIN_CTRL, 16'h0077);
      rd(mcpwm_pkg::A_PIN_CTRL, 16'h0000, 16'hFFFF);
      unlock();
      wr(mcpwm_pkg::A_PIN_CTRL, 16'h0077);
      rd(mcpwm_pkg::A_PIN_CTRL, 16'h0077, 16'hFFFF);
      wr(mcpwm_pkg::A_PIN_CTRL, 16'h0000);
      rd(mcpwm_pkg::A_PIN_CTRL, 16'h0077, 16'hFFFF);
      idle(0);
      wp <= 1'b0;
      wr(mcpwm_pkg::A_FLT_B_CTRL, 16'h0000);
      rd(mcpwm_pkg::A_FLT_B_CTRL, 16'h0000, 16'hFFFF);
      idle(2);
      check({15'h0, pd_b}, 16'h0000);
      wr(mcpwm_pkg::A_FLT_B_CTRL, 16'h0003);
      idle(0);
      wp <= 1'b1;
      $display("test protection done");
      for (int i = 0; i < 4; i++) begin
         v = 16'($urandom);
         wr(mcpwm_pkg::A_TB_CTRL, 16'h0000);
         wr(mcpwm_pkg::A_TB_PERIOD, v);
         rd(mcpwm_pkg::A_TB_PERIOD, v & 16'h7FFF, 16'hFFFF);
         wr(mcpwm_pkg::A_TB_COUNT, v);
         rd(mcpwm_pkg::A_TB_COUNT, v, 16'h7FFF);
      end
      idle(2);
      $display("test registers done");
      for (int i = 0; i < 6; i++) begin
         tb_setup(tper[i], tctl[i]);
         gap(n);
         gap(n);
         gap(n);
         check(16'(n), 16'(tgap[i]));
      end
      tb_setup(16'h0003, 16'h8001);
      idle(30);
      rd(mcpwm_pkg::A_TB_CTRL, 16'h0001, 16'hFFFF);
      tb_setup(16'h0004, 16'h800E);
      gap(n);
      gap(n);
      idle(150);
      rd(mcpwm_pkg::A_TB_COUNT, 16'h0000, 16'h8000);
      idle(250);
      rd(mcpwm_pkg::A_TB_COUNT, 16'h8000, 16'h8000);
      tb_setup(16'h0001, 16'hA000);
      cpu_idle <= 1'b1;
      count_ev(100, k);
      check(16'(k), 16'h0000);
      cpu_idle <= 1'b0;
      count_ev(100, k);
      check(16'(k), 16'h0031);
      tb_setup(16'h0001, 16'h0000);
      count_ev(100, k);
      check(16'(k), 16'h0000);
      $display("test time base done");
      wr(mcpwm_pkg::A_FLT_STATUS, 16'h0003);
      rd(mcpwm_pkg::A_FLT_STATUS, 16'h0000, 16'h0003);
      wr(mcpwm_pkg::A_DUTY1, 16'h0002);
      wr(mcpwm_pkg::A_DUTY2, 16'h0002);
      wr(mcpwm_pkg::A_DUTY3, 16'h0002);
      tb_setup(16'h0003, 16'h8000);
      check({10'h0, hi_oe, lo_oe}, 16'h003F);
      idle(12);
      watch(1'b1, 8);
      flt_a <= 1'b1;
      idle(6);
      watch(1'b0, 8);
      flt_a <= 1'b0;
      idle(10);
      watch(1'b0, 8);
      wr(mcpwm_pkg::A_FLT_STATUS, 16'h0001);
      idle(12);
      watch(1'b1, 8);
      con_b <= 1'b0;
      idle(6);
      watch(1'b0, 8);
      $display("test faults done");
      end_of_test();
   end
endmodule
`default_nettype wire
